// >>> hdl/bit_set_and_test_skip_exec.sv
// executor for bit set and bit test skip if clear instructions
// Summary of operation
// - bit_set_instr writes a one into the chosen bit and keeps the other seven bits.
// - bit_test_skip_clear_instr reads the chosen bit and skips the next word only if zero.
// - a taken skip discards the prefetched word and runs no_operation instead.
// - the test takes one cycle when the bit is one and two when the skip is taken.
`include "bit_exec_defines.svh"
module bit_set_and_test_skip_exec (
    // clock and reset
    input wire clk,
    input wire rst_n,
    input wire clk_en,
    // instruction from fetch, valid each instruction cycle
    input wire bit_exec_pkg::instr_type instr,
    input wire instr_valid,
    // file register read port (combinational, addressed by rd_addr)
    output bit_exec_pkg::faddr_type rd_addr,
    input wire bit_exec_pkg::data_type rd_data,
    // file register write port
    output bit_exec_pkg::faddr_type wr_addr,
    output bit_exec_pkg::data_type wr_data,
    output logic wr_en,
    // pipeline control
    output logic skip_active,
    output logic executed_nop
);
    import bit_exec_pkg::*;
    bit_decode_if dcd ();
    logic skip_q;
    logic skip_d;
    logic do_exec;
    data_type set_value;
    // assertion helpers
    logic set_word;
    logic test_word;
    logic [2:0] bit_seen_q;
    faddr_type addr_seen_q;
    bit_instr_decode u_decode (
        .instr(instr),
        .squash(skip_q),
        .dec(dcd.dec)
    );
    // read address taken combinationally from the address field of instr
    assign rd_addr = instr[`ADDR_HI:`ADDR_LO];
    assign do_exec = clk_en && instr_valid;
    // per-bit merge: only the selected bit is forced high
    for (genvar i = 0; i < $bits(data_type); i++) begin : g_set_bit
        assign set_value[i] = rd_data[i] | (dcd.bit_sel == 3'(i));
    end
    // skip when tested bit clear; the squashed slot itself never skips
    assign skip_d = (dcd.op == op_test_type) && !rd_data[dcd.bit_sel];
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            skip_q <= 1'b0;
        end else if (do_exec) begin
            skip_q <= skip_d;
        end
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_en <= 1'b0;
            wr_addr <= `ADDR_RESET;
            wr_data <= `DATA_RESET;
        end else if (clk_en) begin
            wr_en <= instr_valid && (dcd.op == op_set_type);
            wr_addr <= dcd.addr;
            wr_data <= set_value;
        end
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            skip_active <= 1'b0;
            executed_nop <= 1'b0;
        end else if (clk_en) begin
            skip_active <= do_exec ? skip_d : skip_q;
            executed_nop <= do_exec && skip_q;
        end
    end
    // status flags have no port here: nothing to touch
    property p_set_writes_one;
        @(posedge clk) disable iff (!rst_n)
        (clk_en && instr_valid && !skip_q && instr[11:8] == 4'h5)
            |=> (wr_en && wr_data[bit_seen_q] == 1'b1);
    endproperty
    a_set_writes_one: assert property (p_set_writes_one)
        else $error("set bit not written");
    property p_set_keeps_others;
        @(posedge clk) disable iff (!rst_n)
        (clk_en && instr_valid && !skip_q && instr[11:8] == 4'h5)
            |=> ((wr_data | (8'h01 << bit_seen_q))
                == ($past(rd_data) | (8'h01 << bit_seen_q)));
    endproperty
    a_set_keeps_others: assert property (p_set_keeps_others)
        else $error("other bits changed");
    property p_test_clear_skips;
        @(posedge clk) disable iff (!rst_n)
        (clk_en && instr_valid && !skip_q && instr[11:8] == 4'h6 && !rd_data[instr[7:5]])
            |=> skip_active;
    endproperty
    a_test_clear_skips: assert property (p_test_clear_skips)
        else $error("skip missed");
    property p_test_set_no_skip;
        @(posedge clk) disable iff (!rst_n)
        (clk_en && instr_valid && !skip_q && instr[11:8] == 4'h6 && rd_data[instr[7:5]])
            |=> !skip_active;
    endproperty
    a_test_set_no_skip: assert property (p_test_set_no_skip)
        else $error("false skip");
    sequence s_skip_taken;
        clk_en && instr_valid && skip_d;
    endsequence
    sequence s_squashed_slot;
        skip_q && skip_active && !wr_en;
    endsequence

    sequence s_slot_consumed;
        clk_en && instr_valid && skip_q;
    endsequence

    // the slot may wait on idle or frozen cycles before it is consumed
    property p_squash_nop;
        @(posedge clk) disable iff (!rst_n)
        s_skip_taken |=> s_squashed_slot;
    endproperty
    a_squash_nop: assert property (p_squash_nop)
        else $error("discarded word ran");

    property p_slot_runs_nop;
        @(posedge clk) disable iff (!rst_n)
        s_slot_consumed |=> (executed_nop && !wr_en && !skip_q);
    endproperty
    a_slot_runs_nop: assert property (p_slot_runs_nop)
        else $error("squashed slot did not run as no_operation");
    property p_two_cycles;
        @(posedge clk) disable iff (!rst_n)
        (s_skip_taken ##1 (clk_en && instr_valid)) |=> !skip_q;
    endproperty
    a_two_cycles: assert property (p_two_cycles)
        else $error("skip longer than one slot");
    property p_no_chain;
        @(posedge clk) disable iff (!rst_n)
        skip_q |-> !skip_d;
    endproperty
    a_no_chain: assert property (p_no_chain)
        else $error("squashed slot skipped");
    property p_other_op_no_write;
        @(posedge clk) disable iff (!rst_n)
        (clk_en && instr_valid && instr[11:8] != 4'h5) |=> !wr_en;
    endproperty
    a_other_op_no_write: assert property (p_other_op_no_write)
        else $error("stray write");

    // opcode of the present word, fields of the word at the last clk_en cycle, valid or not
    assign set_word = instr[`OPC_HI:`OPC_LO] == `OPC_BIT_SET;
    assign test_word = instr[`OPC_HI:`OPC_LO] == `OPC_BIT_TEST_CLR;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            bit_seen_q <= 3'h0;
            addr_seen_q <= `ADDR_RESET;
        end else if (clk_en) begin
            bit_seen_q <= instr[`BIT_HI:`BIT_LO];
            addr_seen_q <= instr[`ADDR_HI:`ADDR_LO];
        end
    end

    property p_reset_quiet;
        @(posedge clk)
        !rst_n |=> (!wr_en && !skip_active && !executed_nop && !skip_q);
    endproperty
    a_reset_quiet: assert property (p_reset_quiet)
        else $error("state left after reset");

    property p_freeze_holds;
        @(posedge clk) disable iff (!rst_n)
        !clk_en |=> ($stable(wr_en) && $stable(wr_addr) && $stable(wr_data)
            && $stable(skip_active) && $stable(executed_nop) && $stable(skip_q));
    endproperty
    a_freeze_holds: assert property (p_freeze_holds)
        else $error("state moved while frozen");

    property p_set_addr;
        @(posedge clk) disable iff (!rst_n)
        (clk_en && instr_valid && !skip_q && set_word) |=> (wr_addr == addr_seen_q);
    endproperty
    a_set_addr: assert property (p_set_addr)
        else $error("write went to wrong register");

    property p_nop_only_after_skip;
        @(posedge clk) disable iff (!rst_n)
        (clk_en && !(do_exec && skip_q)) |=> !executed_nop;
    endproperty
    a_nop_only_after_skip: assert property (p_nop_only_after_skip)
        else $error("no_operation flagged without a skip");

    property p_skip_one_slot;
        @(posedge clk) disable iff (!rst_n)
        (clk_en && instr_valid && skip_active) |=> !skip_active;
    endproperty
    a_skip_one_slot: assert property (p_skip_one_slot)
        else $error("skip covered more than one word");

    property p_skip_waits;
        @(posedge clk) disable iff (!rst_n)
        (clk_en && !instr_valid && skip_q) |=> skip_q;
    endproperty
    a_skip_waits: assert property (p_skip_waits)
        else $error("pending skip lost on idle cycle");

    property p_idle_no_write;
        @(posedge clk) disable iff (!rst_n)
        (clk_en && !instr_valid) |=> !wr_en;
    endproperty
    a_idle_no_write: assert property (p_idle_no_write)
        else $error("write on idle cycle");

    property p_squashed_set_no_write;
        @(posedge clk) disable iff (!rst_n)
        (clk_en && instr_valid && skip_q && set_word) |=> !wr_en;
    endproperty
    a_squashed_set_no_write: assert property (p_squashed_set_no_write)
        else $error("squashed set wrote");

    property p_set_no_skip;
        @(posedge clk) disable iff (!rst_n)
        (clk_en && instr_valid && set_word) |=> !skip_active;
    endproperty
    a_set_no_skip: assert property (p_set_no_skip)
        else $error("set word started a skip");

    property p_write_needs_set;
        @(posedge clk) disable iff (!rst_n)
        (clk_en && !(instr_valid && !skip_q && set_word)) |=> !wr_en;
    endproperty
    a_write_needs_set: assert property (p_write_needs_set)
        else $error("write without an executed set");

    property p_test_no_write;
        @(posedge clk) disable iff (!rst_n)
        (clk_en && instr_valid && test_word) |=> !wr_en;
    endproperty
    a_test_no_write: assert property (p_test_no_write)
        else $error("test word wrote");
endmodule // bit_set_and_test_skip_exec

// >>> hdl/bit_exec_defines.svh
// bit instruction encodings and field positions
`ifndef BIT_EXEC_DEFINES_SVH
`define BIT_EXEC_DEFINES_SVH
`define OPC_HI 11
`define OPC_LO 8
`define OPC_BIT_SET 4'h5
`define OPC_BIT_TEST_CLR 4'h6
`define BIT_HI 7
`define BIT_LO 5
`define ADDR_HI 4
`define ADDR_LO 0
`define INSTR_RESET 12'h000
`define DATA_RESET 8'h00
`define ADDR_RESET 5'h00
`endif

// >>> hdl/bit_exec_pkg.sv
// types shared by the bit instruction executor
package bit_exec_pkg;
    typedef logic [11:0] instr_type;
    typedef logic [7:0] data_type;
    typedef logic [4:0] faddr_type;
    typedef enum logic [1:0] {op_none_type, op_set_type, op_test_type} op_type;
endpackage

// >>> hdl/bit_decode_if.sv
// decoded fields passed from decoder to executor
interface bit_decode_if;
    import bit_exec_pkg::*;
    op_type op;
    logic [2:0] bit_sel;
    faddr_type addr;
    modport dec (output op, output bit_sel, output addr);
    modport exe (input op, input bit_sel, input addr);
endinterface

// >>> hdl/bit_instr_decode.sv
// combinational field decoder for the two bit instructions
`include "bit_exec_defines.svh"
module bit_instr_decode (
    // instruction word and squash flag
    input wire bit_exec_pkg::instr_type instr,
    input wire squash,
    // decoded fields
    bit_decode_if.dec dec
);
    import bit_exec_pkg::*;
    logic [3:0] opc;
    assign opc = instr[`OPC_HI:`OPC_LO];
    always_comb begin
        dec.bit_sel = instr[`BIT_HI:`BIT_LO];
        dec.addr = instr[`ADDR_HI:`ADDR_LO];
        // squashed word decodes as no_operation
        if (squash) begin
            dec.op = op_none_type;
        end else if (opc == `OPC_BIT_SET) begin
            dec.op = op_set_type;
        end else if (opc == `OPC_BIT_TEST_CLR) begin
            dec.op = op_test_type;
        end else begin
            dec.op = op_none_type;
        end
    end
endmodule // bit_instr_decode

// >>> tb/bit_set_and_test_skip_exec_test.sv
// self-checking bench for the bit set and bit test skip executor
module bit_set_and_test_skip_exec_test;
    timeunit 1ns;
    timeprecision 1ns;
    import bit_exec_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic clk_en = 1'b0;
    logic instr_valid = 1'b0;
    instr_type instr = 12'h000;
    data_type rd_data = 8'h00;
    faddr_type rd_addr;
    faddr_type wr_addr;
    data_type wr_data;
    logic wr_en;
    logic skip_active;
    logic executed_nop;
    int err_total = 0;
    int checks = 0;
    int cyc = 0;
    always #50 clk = ~clk;
    bit_set_and_test_skip_exec u_dut (
        .clk(clk), .rst_n(rst_n), .clk_en(clk_en), .instr(instr), .instr_valid(instr_valid),
        .rd_addr(rd_addr), .rd_data(rd_data), .wr_addr(wr_addr), .wr_data(wr_data),
        .wr_en(wr_en), .skip_active(skip_active), .executed_nop(executed_nop));
    task automatic chk(input string name, input logic [11:0] exp, input logic [11:0] got);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask
    // drive one word at the falling edge
    task automatic step(input instr_type w, input data_type d, input logic v, input logic en);
        @(negedge clk);
        instr = w;
        rd_data = d;
        instr_valid = v;
        clk_en = en;
    endtask
    // every bit index, back to back, other bits kept
    task automatic t_set_all;
        for (int b = 0; b < 9; b++) begin
            step(b < 8 ? {4'h5, b[2:0], 5'(b + 8)} : 12'h000, 8'hA5 & ~(8'h01 << b), b < 8, 1'b1);
            #1 if (b < 8) chk("rd_addr", 12'(b + 8), 12'(rd_addr));
            if (b > 0) begin
                chk("wr_en", 12'h001, 12'(wr_en));
                chk("wr_addr", 12'(b + 7), 12'(wr_addr));
                chk("wr_data", 12'(8'hA5 | (8'h01 << (b - 1))), 12'(wr_data));
            end
        end
    endtask
    // skip taken: next set is squashed into a no_operation
    task automatic t_skip;
        step(12'h621, 8'hFD, 1'b1, 1'b1);
        step(12'h5E3, 8'h00, 1'b1, 1'b1);
        chk("skip_active", 12'h001, 12'(skip_active));
        step(12'h000, 8'h00, 1'b0, 1'b1);
        chk("wr_en", 12'h000, 12'(wr_en));
        chk("skip_active", 12'h000, 12'(skip_active));
        chk("executed_nop", 12'h001, 12'(executed_nop));
    endtask
    // bit one: no skip, next word runs in the following cycle
    task automatic t_noskip;
        step(12'h621, 8'h02, 1'b1, 1'b1);
        step(12'h5E3, 8'h0A, 1'b1, 1'b1);
        chk("skip_active", 12'h000, 12'(skip_active));
        step(12'h000, 8'h00, 1'b0, 1'b1);
        chk("wr_data", 12'h08A, 12'(wr_data));
        chk("wr_en", 12'h001, 12'(wr_en));
        chk("executed_nop", 12'h000, 12'(executed_nop));
    endtask
    // other opcodes and a frozen cycle do nothing
    task automatic t_ignored;
        step(12'h4E3, 8'hFF, 1'b1, 1'b1);
        step(12'h700, 8'h00, 1'b1, 1'b1);
        chk("wr_en", 12'h000, 12'(wr_en));
        step(12'h5E3, 8'h00, 1'b1, 1'b0);
        chk("skip_active", 12'h000, 12'(skip_active));
        step(12'h000, 8'h00, 1'b0, 1'b1);
        chk("wr_en", 12'h000, 12'(wr_en));
    endtask
    // every bit index: a clear bit skips, a set bit does not
    task automatic t_test_bits;
        for (int b = 0; b < 16; b++) begin
            step({4'h6, b[2:0], 5'h04},
                b < 8 ? ~(8'h01 << b[2:0]) : 8'h01 << b[2:0], 1'b1, 1'b1);
            #1 chk("rd_addr", 12'h004, 12'(rd_addr));
            step(12'h000, 8'h00, 1'b1, 1'b1);
            chk("skip_active", 12'(b < 8), 12'(skip_active));
            step(12'h000, 8'h00, 1'b0, 1'b1);
            chk("executed_nop", 12'(b < 8), 12'(executed_nop));
        end
    endtask
    // pending skip waits through idle and frozen cycles; squashed test never chains
    task automatic t_skip_hold;
        step(12'h621, 8'h00, 1'b1, 1'b1);
        step(12'h000, 8'h00, 1'b0, 1'b1);
        step(12'h621, 8'h00, 1'b1, 1'b0);
        chk("skip_active", 12'h001, 12'(skip_active));
        step(12'h621, 8'h00, 1'b1, 1'b1);
        step(12'h5E3, 8'h0A, 1'b1, 1'b1);
        chk("skip_active", 12'h000, 12'(skip_active));
        chk("executed_nop", 12'h001, 12'(executed_nop));
        step(12'h000, 8'h00, 1'b0, 1'b1);
        chk("wr_en", 12'h001, 12'(wr_en));
        chk("wr_data", 12'h08A, 12'(wr_data));
    endtask
    // reset in mid-run drops a pending skip
    task automatic t_reset;
        step(12'h621, 8'h00, 1'b1, 1'b1);
        step(12'h5E3, 8'h0A, 1'b1, 1'b1);
        rst_n = 1'b0;
        #1 chk("skip_active", 12'h000, 12'(skip_active));
        step(12'h5E3, 8'h0A, 1'b1, 1'b1);
        rst_n = 1'b1;
        step(12'h000, 8'h00, 1'b0, 1'b1);
        chk("wr_en", 12'h001, 12'(wr_en));
        chk("wr_data", 12'h08A, 12'(wr_data));
    endtask
    task automatic print_verdict;
        $display("checks %0d err_total %0d", checks, err_total);
        if (err_total == 0 && checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 400) begin
            err_total++;
            print_verdict();
        end
    end
    initial begin
        repeat (6) @(negedge clk);
        rst_n = 1'b1;
        chk("wr_en", 12'h000, 12'(wr_en));
        t_set_all();
        t_skip();
        t_noskip();
        t_ignored();
        t_test_bits();
        t_skip_hold();
        t_reset();
        print_verdict();
    end
endmodule // bit_set_and_test_skip_exec_test
